// ---- design/port_function_mux.sv ----
// Twenty-port function selector with AXI4-Lite registers and interrupt.
// Assumes pin levels arrive asynchronously from the port comparators and
// converter samples arrive on clock_in from the converter sequencer.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// RULE1: Each of 20 ports keeps a 4-bit function code in config bits 15:12.
// RULE2: Software should pass through high impedance between function modes.
// RULE3: Code 0000 leaves the port undriven with all digital paths off.
// RULE4: Code 0001 is a threshold input; above converter threshold reads one.
// RULE5: Input setup: mask, write threshold, wait 1ms, set mode, unmask.
// RULE6: Each input comparison result reads back in the input level bits.
// RULE7: Code 0010 on lower port pairs it with the next port; that one hi-z.
// RULE8: Software never programs the translator code on port 19.
// RULE9: Translator activity shows on input path; input bits set up alike.
// RULE10: Code 0011 drives the port from its output level bit.
// RULE11: Software writes output level data and waits 1ms before code 0011.
// RULE12: Code 0100 drives the port with a named source input port's data.
// RULE13: Forwarded data is inverted when the invert bit is set.
// RULE14: Several forwarding ports may share one source and all receive it.
// RULE15: Analog output span codes are limited to 001, 010 or 011; the code has no span field.
// RULE16: Monitor mode stores each converter sample in the port's data reg.
// RULE17: Code 0101 selects plain analog output following the port's data.
// RULE18: Code 0110 selects analog output with converter monitoring.
// RULE19: Codes decode per port except pairing and source relations.
module port_function_mux (
   input wire logic clock_in,
   input wire logic rst_b_in,
   input wire logic [port_mux_pkg::ADDR_W-1:0] s_axi_awaddr_in,
   input wire logic s_axi_awvalid_in,
   output logic s_axi_awready_out,
   input wire logic [31:0] s_axi_wdata_in,
   input wire logic [3:0] s_axi_wstrb_in,
   input wire logic s_axi_wvalid_in,
   output logic s_axi_wready_out,
   output logic [1:0] s_axi_bresp_out,
   output logic s_axi_bvalid_out,
   input wire logic s_axi_bready_in,
   input wire logic [port_mux_pkg::ADDR_W-1:0] s_axi_araddr_in,
   input wire logic s_axi_arvalid_in,
   output logic s_axi_arready_out,
   output logic [31:0] s_axi_rdata_out,
   output logic [1:0] s_axi_rresp_out,
   output logic s_axi_rvalid_out,
   input wire logic s_axi_rready_in,
   input wire logic [port_mux_pkg::NUM_PORTS-1:0] pin_level_in,
   output logic [port_mux_pkg::NUM_PORTS-1:0] pin_out,
   output logic [port_mux_pkg::NUM_PORTS-1:0] pin_oe_b_out,
   output logic [port_mux_pkg::NUM_PORTS-1:0] dac_en_out,
   output logic [port_mux_pkg::NUM_PORTS-1:0] adc_mon_out,
   output logic [port_mux_pkg::NUM_PORTS-1:0][port_mux_pkg::DAC_W-1:0]
      dac_code_out,
   input wire port_mux_pkg::adc_sample_t adc_sample_in,
   output logic irq_out
);
   import port_mux_pkg::*;

   typedef logic [NUM_PORTS-1:0] vec_t;
   typedef logic [NUM_PORTS-1:0][DAC_W-1:0] bank_t;

   // Index of a word inside a 20-word bank, or NUM_PORTS when outside
   function automatic logic [4:0] bank_idx(
      input logic [ADDR_W-1:0] addr,
      input logic [ADDR_W-1:0] base);
      logic [ADDR_W-1:0] off;
      off = addr - base;
      if (addr >= base && off < BANK_BYTES && addr[1:0] == 2'h0) begin
         bank_idx = off[6:2];
      end else begin
         bank_idx = 5'(NUM_PORTS);
      end
   endfunction

   function automatic logic [31:0] merge(
      input logic [31:0] old,
      input logic [31:0] data,
      input logic [3:0] strb);
      merge = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            merge[b*8 +: 8] = data[b*8 +: 8];
         end
      end
   endfunction

   function automatic logic [31:0] cfg_word(input port_cfg_t c);
      cfg_word = 32'h0;
      cfg_word[CFG_FN_LSB +: 4] = c.fn;
      cfg_word[CFG_INV_BIT] = c.invert_source;
      cfg_word[CFG_SRC_LSB +: 5] = c.src;
   endfunction

   // RULE1 per-port function codes
   port_cfg_t [NUM_PORTS-1:0] cfg_q, cfg_d;
   bank_t dac_q, dac_d, adc_q, adc_d;
   vec_t out_lvl_q, out_lvl_d, ev_mask_q, ev_mask_d;
   vec_t ev_mode_q, ev_mode_d, ev_stat_q, ev_stat_d;
   vec_t irq_mask_q, irq_mask_d;
   vec_t meta_q, sync_q, lvl_prev_q;
   logic irq_q, irq_d;
   logic bvalid_q, bvalid_d, rvalid_q, rvalid_d;
   logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
   logic [31:0] rdata_q, rdata_d;
   logic wr_go, rd_go;
   vec_t in_lvl, thresh, ev_hit, src_lvl;
   port_drive_t [NUM_PORTS-1:0] drv;

   // Comparator results come from the analog side, so resynchronise
   always_ff @(posedge clock_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         meta_q <= VEC_RST;
         sync_q <= VEC_RST;
      end else begin
         meta_q <= pin_level_in;
         sync_q <= meta_q;
      end
   end

   // RULE6 input level read-back
   assign in_lvl = sync_q & thresh;

   // RULE14 shared source fan-out
   always_comb begin
      for (int i = 0; i < NUM_PORTS; i++) begin
         src_lvl[i] = 1'b0;
         if (cfg_q[i].src < 5'(NUM_PORTS)) begin
            src_lvl[i] = in_lvl[cfg_q[i].src];
         end
      end
   end

   for (genvar i = 0; i < NUM_PORTS; i++) begin : g_port
      logic partner_lvl;
      logic pulled;
      if (i < NUM_PORTS - 1) begin : g_pair
         assign partner_lvl = sync_q[i+1];
      end else begin : g_last
         assign partner_lvl = 1'b1;
      end
      if (i > 0) begin : g_low
         assign pulled = drv[i-1].pull_partner;
      end else begin : g_first
         assign pulled = 1'b0;
      end
      port_function_unit u_unit (
         .clock_in(clock_in),
         .rst_b_in(rst_b_in),
         .cfg_in(cfg_q[i]),
         .partner_ok_in(1'(i < NUM_PORTS - 1)),
         .own_level_in(sync_q[i]),
         .partner_level_in(partner_lvl),
         .src_level_in(src_lvl[i]),
         .out_bit_in(out_lvl_q[i]),
         .drive_out(drv[i])
      );
      assign thresh[i] = drv[i].thresh_en;
      // RULE7 upper port pulled low
      assign pin_oe_b_out[i] = drv[i].pin_oe_b & !pulled;
      assign pin_out[i] = drv[i].pin_out;
      assign dac_en_out[i] = drv[i].dac_en;
      assign adc_mon_out[i] = drv[i].adc_mon;
   end

   // Event on rising edge, or falling edge when the mode bit is set
   always_comb begin
      ev_hit = (ev_mode_q & lvl_prev_q & ~in_lvl) |
               (~ev_mode_q & ~lvl_prev_q & in_lvl);
      ev_hit = ev_hit & ~ev_mask_q;
   end

   // A write is taken only with both halves present and a read with its
   // address, neither with an answer pending, so one of each is outstanding at a time.
   assign wr_go = s_axi_awvalid_in && s_axi_wvalid_in && !bvalid_q;
   assign rd_go = s_axi_arvalid_in && !rvalid_q;

   always_comb begin
      logic [4:0] ci;
      logic [4:0] di;
      logic [4:0] ri;
      logic [31:0] w;
      logic hit;
      ci = bank_idx(s_axi_awaddr_in, CFG_BASE);
      di = bank_idx(s_axi_awaddr_in, DAC_BASE);
      ri = bank_idx(s_axi_araddr_in, 9'h000);
      w = 32'h0;
      hit = 1'b0;
      cfg_d = cfg_q;
      dac_d = dac_q;
      adc_d = adc_q;
      out_lvl_d = out_lvl_q;
      ev_mask_d = ev_mask_q;
      ev_mode_d = ev_mode_q;
      ev_stat_d = ev_stat_q;
      irq_mask_d = irq_mask_q;
      bvalid_d = bvalid_q && !s_axi_bready_in;
      bresp_d = bresp_q;
      rvalid_d = rvalid_q && !s_axi_rready_in;
      rresp_d = rresp_q;
      rdata_d = rdata_q;
      if (wr_go) begin
         hit = 1'b1;
         if (ci < 5'(NUM_PORTS)) begin
            w = merge(cfg_word(cfg_q[ci]), s_axi_wdata_in, s_axi_wstrb_in);
            cfg_d[ci].fn = w[CFG_FN_LSB +: 4];
            cfg_d[ci].invert_source = w[CFG_INV_BIT];
            cfg_d[ci].src = w[CFG_SRC_LSB +: 5];
         end else if (di < 5'(NUM_PORTS)) begin
            w = merge({20'h0, dac_q[di]}, s_axi_wdata_in, s_axi_wstrb_in);
            dac_d[di] = w[DAC_W-1:0];
         end else begin
            case (s_axi_awaddr_in)
               OUT_LVL_ADDR: begin
                  w = merge({12'h0, out_lvl_q}, s_axi_wdata_in,
                            s_axi_wstrb_in);
                  out_lvl_d = w[NUM_PORTS-1:0];
               end
               EV_MASK_ADDR: begin
                  w = merge({12'h0, ev_mask_q}, s_axi_wdata_in,
                            s_axi_wstrb_in);
                  ev_mask_d = w[NUM_PORTS-1:0];
               end
               EV_MODE_ADDR: begin
                  w = merge({12'h0, ev_mode_q}, s_axi_wdata_in,
                            s_axi_wstrb_in);
                  ev_mode_d = w[NUM_PORTS-1:0];
               end
               EV_STAT_ADDR: begin
                  w = merge(32'h0, s_axi_wdata_in, s_axi_wstrb_in);
                  ev_stat_d = ev_stat_q & ~w[NUM_PORTS-1:0];
               end
               IRQ_MASK_ADDR: begin
                  w = merge({12'h0, irq_mask_q}, s_axi_wdata_in,
                            s_axi_wstrb_in);
                  irq_mask_d = w[NUM_PORTS-1:0];
               end
               IN_LVL_ADDR: hit = 1'b1;
               default: hit = 1'b0;
            endcase
         end
         bvalid_d = 1'b1;
         bresp_d = hit ? RESP_OKAY : RESP_SLVERR;
      end
      // New events win over a clear in the same cycle
      ev_stat_d = ev_stat_d | ev_hit;
      // RULE16 store monitor samples
      if (adc_sample_in.valid && adc_sample_in.port < 5'(NUM_PORTS)) begin
         if (drv[adc_sample_in.port].adc_mon) begin
            adc_d[adc_sample_in.port] = adc_sample_in.data;
         end
      end
      if (rd_go) begin
         rvalid_d = 1'b1;
         rresp_d = RESP_OKAY;
         rdata_d = 32'h0;
         ri = bank_idx(s_axi_araddr_in, CFG_BASE);
         if (ri < 5'(NUM_PORTS)) begin
            rdata_d = cfg_word(cfg_q[ri]);
         end else if (bank_idx(s_axi_araddr_in, DAC_BASE) < 5'(NUM_PORTS))
         begin
            rdata_d[DAC_W-1:0] = dac_q[bank_idx(s_axi_araddr_in, DAC_BASE)];
         end else if (bank_idx(s_axi_araddr_in, ADC_BASE) < 5'(NUM_PORTS))
         begin
            rdata_d[DAC_W-1:0] = adc_q[bank_idx(s_axi_araddr_in, ADC_BASE)];
         end else begin
            case (s_axi_araddr_in)
               IN_LVL_ADDR: rdata_d[NUM_PORTS-1:0] = in_lvl;
               OUT_LVL_ADDR: rdata_d[NUM_PORTS-1:0] = out_lvl_q;
               EV_MASK_ADDR: rdata_d[NUM_PORTS-1:0] = ev_mask_q;
               EV_MODE_ADDR: rdata_d[NUM_PORTS-1:0] = ev_mode_q;
               EV_STAT_ADDR: rdata_d[NUM_PORTS-1:0] = ev_stat_q;
               IRQ_MASK_ADDR: rdata_d[NUM_PORTS-1:0] = irq_mask_q;
               default: rresp_d = RESP_SLVERR;
            endcase
         end
      end
      irq_d = |(ev_stat_q & irq_mask_q);
   end

   always_ff @(posedge clock_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         cfg_q <= '0;
         dac_q <= '0;
         adc_q <= '0;
         out_lvl_q <= VEC_RST;
         ev_mask_q <= EV_MASK_RST;
         ev_mode_q <= VEC_RST;
         ev_stat_q <= VEC_RST;
         irq_mask_q <= VEC_RST;
         lvl_prev_q <= VEC_RST;
         irq_q <= 1'b0;
         bvalid_q <= 1'b0;
         bresp_q <= RESP_OKAY;
         rvalid_q <= 1'b0;
         rresp_q <= RESP_OKAY;
         rdata_q <= 32'h0;
      end else begin
         cfg_q <= cfg_d;
         dac_q <= dac_d;
         adc_q <= adc_d;
         out_lvl_q <= out_lvl_d;
         ev_mask_q <= ev_mask_d;
         ev_mode_q <= ev_mode_d;
         ev_stat_q <= ev_stat_d;
         irq_mask_q <= irq_mask_d;
         lvl_prev_q <= in_lvl;
         irq_q <= irq_d;
         bvalid_q <= bvalid_d;
         bresp_q <= bresp_d;
         rvalid_q <= rvalid_d;
         rresp_q <= rresp_d;
         rdata_q <= rdata_d;
      end
   end

   assign s_axi_awready_out = wr_go;
   assign s_axi_wready_out = wr_go;
   assign s_axi_bvalid_out = bvalid_q;
   assign s_axi_bresp_out = bresp_q;
   assign s_axi_arready_out = rd_go;
   assign s_axi_rvalid_out = rvalid_q;
   assign s_axi_rresp_out = rresp_q;
   assign s_axi_rdata_out = rdata_q;
   // Analog codes are held in flops and follow the register directly
   assign dac_code_out = dac_q;
   assign irq_out = irq_q;
endmodule
`default_nettype wire

// ---- design/port_function_unit.sv ----
// One port's function decoder and pair translator direction control.
// Assumes level inputs are already synchronised to clock_in.
`timescale 1ns/1ps
`default_nettype none
module port_function_unit (
   input wire logic clock_in,
   input wire logic rst_b_in,
   input wire port_mux_pkg::port_cfg_t cfg_in,
   input wire logic partner_ok_in,
   input wire logic own_level_in,
   input wire logic partner_level_in,
   input wire logic src_level_in,
   input wire logic out_bit_in,
   output port_mux_pkg::port_drive_t drive_out
);
   import port_mux_pkg::*;

   xlat_state_t xl_q, xl_d;
   port_drive_t drv_q, drv_d;
   logic xlat;

   // RULE7 pair translator enable
   assign xlat = (cfg_in.fn == FN_XLAT) && partner_ok_in;

   // The pulled side reads low too, so a release state waits for it to
   // rise before either side may pull again; this prevents a latch-up.
   always_comb begin
      xl_d = xl_q;
      case (xl_q)
         XL_IDLE: begin
            if (xlat && !partner_level_in) begin
               xl_d = XL_OWN_PULL;
            end else if (xlat && !own_level_in) begin
               xl_d = XL_PART_PULL;
            end
         end
         XL_OWN_PULL: begin
            if (!xlat || partner_level_in) begin
               xl_d = XL_OWN_REL;
            end
         end
         XL_OWN_REL: begin
            if (!xlat || own_level_in) begin
               xl_d = XL_IDLE;
            end
         end
         XL_PART_PULL: begin
            if (!xlat || own_level_in) begin
               xl_d = XL_PART_REL;
            end
         end
         XL_PART_REL: begin
            if (!xlat || partner_level_in) begin
               xl_d = XL_IDLE;
            end
         end
         default: xl_d = XL_IDLE;
      endcase
   end

   // RULE19 per-port decode
   always_comb begin
      drv_d = DRIVE_RST;
      case (cfg_in.fn)
         // RULE3 high impedance
         FN_HIZ: drv_d = DRIVE_RST;
         // RULE4 threshold input
         FN_IN: begin
            drv_d.thresh_en = 1'b1;
            drv_d.dac_en = 1'b1;
         end
         // RULE9 translator via input path
         FN_XLAT: begin
            drv_d.thresh_en = 1'b1;
            drv_d.dac_en = 1'b1;
            drv_d.pin_oe_b = !(xl_d == XL_OWN_PULL);
            drv_d.pull_partner = (xl_d == XL_PART_PULL);
         end
         // RULE10 register-driven output
         FN_OUT: begin
            drv_d.dac_en = 1'b1;
            drv_d.pin_oe_b = 1'b0;
            drv_d.pin_out = out_bit_in;
         end
         // RULE12 forwarded source data
         FN_FWD: begin
            drv_d.dac_en = 1'b1;
            drv_d.pin_oe_b = 1'b0;
            // RULE13 optional inversion
            drv_d.pin_out = src_level_in ^ cfg_in.invert_source;
         end
         // RULE17 plain analog output
         FN_DAC: drv_d.dac_en = 1'b1;
         // RULE18 analog output with monitor
         FN_MON: begin
            drv_d.dac_en = 1'b1;
            drv_d.adc_mon = 1'b1;
         end
         default: drv_d = DRIVE_RST;
      endcase
   end

   always_ff @(posedge clock_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         xl_q <= XL_IDLE;
         drv_q <= DRIVE_RST;
      end else begin
         xl_q <= xl_d;
         drv_q <= drv_d;
      end
   end

   assign drive_out = drv_q;
endmodule
`default_nettype wire

// ---- design/port_mux_pkg.sv ----
// Constants, register map and carrier types of the port function selector.
// Assumes a single 40 MHz clock domain and an AXI4-Lite register bus.
package port_mux_pkg;
   localparam int NUM_PORTS = 20;
   localparam int DAC_W = 12;
   localparam int ADDR_W = 9;
   // Port function codes
   localparam logic [3:0] FN_HIZ = 4'h0;
   localparam logic [3:0] FN_IN = 4'h1;
   localparam logic [3:0] FN_XLAT = 4'h2;
   localparam logic [3:0] FN_OUT = 4'h3;
   localparam logic [3:0] FN_FWD = 4'h4;
   localparam logic [3:0] FN_DAC = 4'h5;
   localparam logic [3:0] FN_MON = 4'h6;
   // Field positions inside a port configuration word
   localparam int CFG_FN_LSB = 12;
   localparam int CFG_INV_BIT = 11;
   localparam int CFG_SRC_LSB = 0;
   // Byte addresses; per-port banks hold one word per port
   localparam logic [ADDR_W-1:0] CFG_BASE = 9'h000;
   localparam logic [ADDR_W-1:0] DAC_BASE = 9'h050;
   localparam logic [ADDR_W-1:0] ADC_BASE = 9'h0A0;
   localparam logic [ADDR_W-1:0] IN_LVL_ADDR = 9'h0F0;
   localparam logic [ADDR_W-1:0] OUT_LVL_ADDR = 9'h0F4;
   localparam logic [ADDR_W-1:0] EV_MASK_ADDR = 9'h0F8;
   localparam logic [ADDR_W-1:0] EV_MODE_ADDR = 9'h0FC;
   localparam logic [ADDR_W-1:0] EV_STAT_ADDR = 9'h100;
   localparam logic [ADDR_W-1:0] IRQ_MASK_ADDR = 9'h104;
   localparam logic [ADDR_W-1:0] BANK_BYTES = 9'h050;
   // Reset values and bus response codes
   localparam logic [NUM_PORTS-1:0] EV_MASK_RST = 20'hFFFFF;
   localparam logic [NUM_PORTS-1:0] VEC_RST = 20'h00000;
   localparam logic [DAC_W-1:0] DAC_RST = 12'h000;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic [3:0] fn;
      logic invert_source;
      logic [4:0] src;
   } port_cfg_t;

   typedef struct packed {
      logic pin_out;
      logic pin_oe_b;
      logic pull_partner;
      logic dac_en;
      logic adc_mon;
      logic thresh_en;
   } port_drive_t;

   typedef struct packed {
      logic valid;
      logic [4:0] port;
      logic [DAC_W-1:0] data;
   } adc_sample_t;

   typedef enum logic [2:0] {
      XL_IDLE = 3'h0,
      XL_OWN_PULL = 3'h1,
      XL_OWN_REL = 3'h2,
      XL_PART_PULL = 3'h3,
      XL_PART_REL = 3'h4
   } xlat_state_t;

   localparam port_drive_t DRIVE_RST = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0,
                                          1'b0};
endpackage

// ---- testbench/port_function_mux_asserts.sv ----
// Concurrent checks on the bus handshakes and pin drive outputs.
// Assumes one clock domain; bound to every port_function_mux.
`timescale 1ns/1ps
`default_nettype none
module port_function_mux_asserts (
   input wire logic clock_in,
   input wire logic rst_b_in,
   input wire logic s_axi_awvalid_in,
   input wire logic s_axi_awready_out,
   input wire logic s_axi_wready_out,
   input wire logic [1:0] s_axi_bresp_out,
   input wire logic s_axi_bvalid_out,
   input wire logic s_axi_bready_in,
   input wire logic s_axi_arvalid_in,
   input wire logic s_axi_arready_out,
   input wire logic [31:0] s_axi_rdata_out,
   input wire logic s_axi_rvalid_out,
   input wire logic s_axi_rready_in,
   input wire logic [port_mux_pkg::NUM_PORTS-1:0] pin_out,
   input wire logic [port_mux_pkg::NUM_PORTS-1:0] pin_oe_b_out,
   input wire logic [port_mux_pkg::NUM_PORTS-1:0] dac_en_out,
   input wire logic [port_mux_pkg::NUM_PORTS-1:0] adc_mon_out,
   input wire logic irq_out
);
   import port_mux_pkg::*;
   logic wr_seen_q;
   logic wr_seen_d;
   default clocking @(posedge clock_in); endclocking
   default disable iff (!rst_b_in);
   // Until the first write nothing may leave the reset hi-z state
   always_comb begin
      wr_seen_d = wr_seen_q | (s_axi_awvalid_in & s_axi_awready_out);
   end
   always_ff @(posedge clock_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         wr_seen_q <= 1'b0;
      end else begin
         wr_seen_q <= wr_seen_d;
      end
   end
   property p_reset_hiz;
      !wr_seen_q |-> (&pin_oe_b_out) && (dac_en_out == '0);
   endproperty
   a_reset_hiz: assert property (p_reset_hiz)
      else $error("port left hi-z before any write");
   property p_undriven_low;
      (pin_out & pin_oe_b_out) == '0;
   endproperty
   a_undriven_low: assert property (p_undriven_low)
      else $error("pin value shown while not driven");
   property p_mon_is_dac;
      (adc_mon_out & ~dac_en_out) == '0;
   endproperty
   a_mon_is_dac: assert property (p_mon_is_dac)
      else $error("monitor without analog output");
   property p_aw_w_pair;
      s_axi_awready_out == s_axi_wready_out;
   endproperty
   a_aw_w_pair: assert property (p_aw_w_pair)
      else $error("address and data ready differ");
   property p_wr_answer;
      s_axi_awvalid_in && s_axi_awready_out |=>
         s_axi_bvalid_out && !s_axi_awready_out;
   endproperty
   a_wr_answer: assert property (p_wr_answer)
      else $error("write response late");
   property p_b_hold;
      s_axi_bvalid_out && !s_axi_bready_in |=>
         s_axi_bvalid_out && $stable(s_axi_bresp_out);
   endproperty
   a_b_hold: assert property (p_b_hold)
      else $error("write response dropped early");
   property p_rd_answer;
      s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out;
   endproperty
   a_rd_answer: assert property (p_rd_answer)
      else $error("read data late");
   property p_r_hold;
      s_axi_rvalid_out && !s_axi_rready_in |=>
         s_axi_rvalid_out && $stable(s_axi_rdata_out);
   endproperty
   a_r_hold: assert property (p_r_hold)
      else $error("read data changed before taken");
   property p_r_block;
      s_axi_rvalid_out |-> !s_axi_arready_out;
   endproperty
   a_r_block: assert property (p_r_block)
      else $error("read accepted while answer pending");
   c_wr: cover property (s_axi_bvalid_out && s_axi_bready_in);
   c_rd: cover property (s_axi_rvalid_out && s_axi_rready_in);
   c_mon: cover property (|adc_mon_out);
   c_irq: cover property ($rose(irq_out));
endmodule
bind port_function_mux port_function_mux_asserts
   port_function_mux_asserts_inst (.*);
`default_nettype wire

// ---- testbench/tb.sv ----
// Self-checking bench for the twenty-port function selector.
// Assumes the package register map; the bench plays host and pin wires.
`timescale 1ns/1ps
`default_nettype none
module tb;
   import port_mux_pkg::*;
   logic clock_in = 1'b0;
   logic rst_b_in = 1'b0;
   logic s_axi_awvalid_in = 1'b0, s_axi_wvalid_in = 1'b0;
   logic s_axi_bready_in = 1'b0, s_axi_arvalid_in = 1'b0;
   logic s_axi_rready_in = 1'b0;
   logic [ADDR_W-1:0] s_axi_awaddr_in = '0, s_axi_araddr_in = '0;
   logic [31:0] s_axi_wdata_in = '0;
   logic [3:0] s_axi_wstrb_in = 4'hF;
   logic s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out;
   logic s_axi_arready_out, s_axi_rvalid_out, irq_out;
   logic [1:0] s_axi_bresp_out, s_axi_rresp_out, rr_q;
   logic [31:0] s_axi_rdata_out, rd_q;
   logic [NUM_PORTS-1:0] pin_level_in, pin_out, pin_oe_b_out;
   logic [NUM_PORTS-1:0] dac_en_out, adc_mon_out, lv_q;
   logic [NUM_PORTS-1:0] lvl_q = '1;
   logic [NUM_PORTS-1:0][DAC_W-1:0] dac_code_out;
   adc_sample_t adc_sample_in = '0;
   logic [3:0] code_q [NUM_PORTS];
   logic [DAC_W-1:0] dac_q [NUM_PORTS];
   // no translator code drawn, no span field
   logic [3:0] tbl [5] = '{FN_HIZ, FN_IN, FN_OUT, FN_DAC, FN_MON};
   integer seed = 32'h59ED;
   int miscompares = 0, n_tests = 0, cyc = 0;
   // Open-drain wire: a port driven low reads low whatever the far side does
   assign pin_level_in = lvl_q & (pin_oe_b_out | pin_out);
   port_function_mux port_function_mux_inst (.*);
   initial begin
      forever #12.5 clock_in = ~clock_in;
   end
   task automatic results();
      $display("Checks %0d, mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   always @(posedge clock_in) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         miscompares++;
         results();
      end
   end
   task automatic chk(input string nm, input logic [31:0] got,
         input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d,
         input logic [1:0] er);
      @(posedge clock_in);
      s_axi_awaddr_in <= a;
      s_axi_wdata_in <= d;
      s_axi_awvalid_in <= 1'b1;
      s_axi_wvalid_in <= 1'b1;
      s_axi_bready_in <= 1'b1;
      do @(posedge clock_in); while (s_axi_awready_out !== 1'b1);
      s_axi_awvalid_in <= 1'b0;
      s_axi_wvalid_in <= 1'b0;
      while (s_axi_bvalid_out !== 1'b1) @(posedge clock_in);
      chk("bresp", 32'(s_axi_bresp_out), 32'(er));
      s_axi_bready_in <= 1'b0;
   endtask
   task automatic rd(input logic [ADDR_W-1:0] a);
      @(posedge clock_in);
      s_axi_araddr_in <= a;
      s_axi_arvalid_in <= 1'b1;
      s_axi_rready_in <= 1'b1;
      do @(posedge clock_in); while (s_axi_arready_out !== 1'b1);
      s_axi_arvalid_in <= 1'b0;
      while (s_axi_rvalid_out !== 1'b1) @(posedge clock_in);
      rd_q = s_axi_rdata_out;
      rr_q = s_axi_rresp_out;
      s_axi_rready_in <= 1'b0;
   endtask
   task automatic setfn(input int p, input logic [3:0] c, input logic invert_source,
         input logic [4:0] s, input logic [DAC_W-1:0] d);
      wr(CFG_BASE + ADDR_W'(4 * p), 32'h0, RESP_OKAY);
      wr(DAC_BASE + ADDR_W'(4 * p), 32'(d), RESP_OKAY);
      wr(CFG_BASE + ADDR_W'(4 * p), {16'h0, c, invert_source, 6'h00, s}, RESP_OKAY);
   endtask
   // Expected {oe_b, pin, analog enable, monitor} for a code with no partner or source
   function automatic logic [3:0] exp_drv(logic [3:0] c, logic ob);
      return {c != FN_OUT, c == FN_OUT && ob, c != FN_HIZ, c == FN_MON};
   endfunction
   initial begin
      repeat (8) @(posedge clock_in);
      rst_b_in <= 1'b1;
      @(posedge clock_in);
      chk("rst_oe", 32'(pin_oe_b_out), 32'hFFFFF);
      rd(EV_MASK_ADDR);
      chk("ev_mask", rd_q, 32'(EV_MASK_RST));
      repeat (2) begin
         for (int i = 0; i < NUM_PORTS; i++) begin
            code_q[i] = tbl[$unsigned($random(seed)) % 5];
            dac_q[i] = DAC_W'($random(seed));
            setfn(i, code_q[i], 1'b0, 5'h00, dac_q[i]);
         end
         lv_q = NUM_PORTS'($random(seed));
         wr(OUT_LVL_ADDR, 32'(lv_q), RESP_OKAY);
         lvl_q <= NUM_PORTS'($random(seed));
         repeat (6) @(posedge clock_in);
         for (int i = 0; i < NUM_PORTS; i++) begin
            chk("drive", 32'({pin_oe_b_out[i], pin_out[i], dac_en_out[i],
               adc_mon_out[i]}), 32'(exp_drv(code_q[i], lv_q[i])));
            chk("dac", 32'(dac_code_out[i]), 32'(dac_q[i]));
            rd(CFG_BASE + ADDR_W'(4 * i));
            chk("code", 32'(rd_q[15:12]), 32'(code_q[i]));
         end
         for (int i = 0; i < NUM_PORTS; i++) begin
            lv_q[i] = (code_q[i] == FN_IN) & lvl_q[i];
         end
         rd(IN_LVL_ADDR);
         chk("in_lvl", rd_q, 32'(lv_q));
      end
      // One source shared by a plain and an inverting forwarder
      setfn(0, FN_IN, 1'b0, 5'h00, 12'h400);
      setfn(5, FN_FWD, 1'b0, 5'h00, 12'h800);
      setfn(6, FN_FWD, 1'b1, 5'h00, 12'h800);
      for (int v = 0; v < 2; v++) begin
         lvl_q[0] <= v[0];
         repeat (6) @(posedge clock_in);
         chk("fwd", 32'({pin_oe_b_out[6:5], pin_out[6:5]}),
            32'({~v[0], v[0]}));
      end
      lvl_q <= '1;
      setfn(3, FN_HIZ, 1'b0, 5'h00, 12'h000);
      setfn(2, FN_XLAT, 1'b0, 5'h00, 12'h400);
      repeat (6) @(posedge clock_in);
      rd(IN_LVL_ADDR);
      chk("xl_lvl", 32'(rd_q[2]), 32'h1);
      for (int j = 0; j < 2; j++) begin
         lvl_q[3 - j] <= 1'b0;
         repeat (6) @(posedge clock_in);
         chk("xl_pull", 32'(pin_oe_b_out[2 + j]), 32'h0);
         lvl_q[3 - j] <= 1'b1;
         repeat (10) @(posedge clock_in);
         chk("xl_rel", 32'(pin_oe_b_out[3:2]), 32'h3);
      end
      setfn(7, FN_MON, 1'b0, 5'h00, 12'h123);
      @(posedge clock_in);
      adc_sample_in <= '{1'b1, 5'h07, 12'hA5C};
      @(posedge clock_in);
      adc_sample_in <= '0;
      repeat (2) @(posedge clock_in);
      rd(ADC_BASE + 9'h01C);
      chk("adc", rd_q, 32'hA5C);
      wr(9'h1FC, 32'h1, RESP_SLVERR);
      wr(ADC_BASE, 32'h1, RESP_SLVERR);
      rd(9'h1FC);
      chk("rresp", {rr_q, rd_q[29:0]}, {RESP_SLVERR, 30'h0});
      // Input events: mask, threshold, edge mode, then unmask
      lvl_q[1] <= 1'b0;
      setfn(1, FN_IN, 1'b0, 5'h00, 12'h300);
      wr(EV_MODE_ADDR, 32'h0, RESP_OKAY);
      wr(EV_MASK_ADDR, 32'hFFFFD, RESP_OKAY);
      wr(IRQ_MASK_ADDR, 32'h2, RESP_OKAY);
      chk("irq_idle", 32'(irq_out), 32'h0);
      lvl_q[1] <= 1'b1;
      repeat (6) @(posedge clock_in);
      chk("irq_set", 32'(irq_out), 32'h1);
      rd(EV_STAT_ADDR);
      chk("ev_stat", rd_q, 32'h2);
      for (int k = 0; k < 3; k++) begin
         wr(k == 2 ? EV_STAT_ADDR : IRQ_MASK_ADDR, k ? 32'h2 : 32'h0,
            RESP_OKAY);
         repeat (2) @(posedge clock_in);
         chk("irq", 32'(irq_out), k == 1 ? 32'h1 : 32'h0);
      end
      rd(EV_STAT_ADDR);
      chk("ev_clr", rd_q, 32'h0);
      results();
   end
endmodule
`default_nettype wire
